/* File: hdl/ceim_pkg.sv */
package ceim_pkg;

	// register byte addresses on the plain register port
	localparam int unsigned ADDR_W            = 12;
	localparam logic [11:0] STATUS_OFFSET     = 12'h120;
	localparam logic [11:0] ENABLE_OFFSET     = 12'h124;
	localparam logic [31:0] STATUS_RESET      = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET      = 32'h0000_0000;

	// client bit positions, shared by the status and enable words
	localparam int unsigned CAP2_ANC_B_BIT          = 29;
	localparam int unsigned CAP2_ANC_A_BIT          = 28;
	localparam int unsigned CAP1_ANC_B_BIT          = 27;
	localparam int unsigned CAP1_ANC_A_BIT          = 26;
	localparam int unsigned XFER2_LUMA_BIT          = 25;
	localparam int unsigned XFER2_CHROMA_BIT        = 24;
	localparam int unsigned XFER1_LUMA_BIT          = 23;
	localparam int unsigned XFER1_CHROMA_BIT        = 22;
	localparam int unsigned HDMI_WRITEBACK_BIT      = 21;
	localparam int unsigned PORT_CTL_BIT            = 20;
	localparam int unsigned VBI_ENC_BIT             = 19;
	localparam int unsigned NR_CHROMA_OUT_FLAG      = 17;
	localparam int unsigned NR_LUMA_OUT_FLAG        = 16;
	localparam int unsigned NR_CHROMA_IN_FLAG       = 15;
	localparam int unsigned NR_LUMA_IN_FLAG         = 14;
	localparam int unsigned NR_PACKED_IN_FLAG       = 13;
	localparam int unsigned GFX3_STREAM_FLAG        = 12;
	localparam int unsigned GFX2_STREAM_FLAG        = 11;
	localparam int unsigned GFX1_STREAM_FLAG        = 10;
	localparam int unsigned CAP2_UPPER_CHROMA_FLAG  = 9;
	localparam int unsigned CAP2_UPPER_LUMA_FLAG    = 8;
	localparam int unsigned CAP2_LOWER_CHROMA_FLAG  = 7;
	localparam int unsigned CAP2_LOWER_LUMA_FLAG    = 6;
	localparam int unsigned CAP1_UPPER_CHROMA_FLAG  = 5;
	localparam int unsigned CAP1_UPPER_LUMA_FLAG    = 4;
	localparam int unsigned CAP1_LOWER_CHROMA_FLAG  = 3;
	localparam int unsigned CAP1_LOWER_LUMA_FLAG    = 2;
	localparam int unsigned GFX3_PAYLOAD_FLAG       = 1;
	localparam int unsigned GFX2_PAYLOAD_FLAG       = 0;

	// implemented bits: 31..30 and 18 are reserved
	localparam logic [31:0] IMPL_MASK = 32'h3FFB_FFFF;

	// clients that receive from a transmitting module default to end of frame received
	localparam logic [31:0] RX_MASK =
		(32'h0000_0001 << CAP2_ANC_B_BIT) | (32'h0000_0001 << CAP2_ANC_A_BIT) |
		(32'h0000_0001 << CAP1_ANC_B_BIT) | (32'h0000_0001 << CAP1_ANC_A_BIT) |
		(32'h0000_0001 << HDMI_WRITEBACK_BIT) |
		(32'h0000_0001 << NR_CHROMA_OUT_FLAG) | (32'h0000_0001 << NR_LUMA_OUT_FLAG) |
		(32'h0000_0001 << CAP2_UPPER_CHROMA_FLAG) | (32'h0000_0001 << CAP2_UPPER_LUMA_FLAG) |
		(32'h0000_0001 << CAP2_LOWER_CHROMA_FLAG) | (32'h0000_0001 << CAP2_LOWER_LUMA_FLAG) |
		(32'h0000_0001 << CAP1_UPPER_CHROMA_FLAG) | (32'h0000_0001 << CAP1_UPPER_LUMA_FLAG) |
		(32'h0000_0001 << CAP1_LOWER_CHROMA_FLAG) | (32'h0000_0001 << CAP1_LOWER_LUMA_FLAG);

	// event that a control descriptor may select, one-hot
	typedef enum logic [3:0] {
		CEIM_EV_EOF_RX = 4'h1,
		CEIM_EV_EOF_TX = 4'h2,
		CEIM_EV_SOF    = 4'h4,
		CEIM_EV_LINE   = 4'h8
	} ceim_event_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ceim_bus_req_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  client;
		ceim_event_t event_sel;
	} ceim_desc_t;

	typedef struct packed {
		logic [31:0] eof_rx;
		logic [31:0] eof_tx;
		logic [31:0] sof;
		logic [31:0] line;
	} ceim_events_t;

	typedef struct packed {
		logic eof_rx;
		logic eof_tx;
		logic sof;
		logic line;
	} ceim_client_ev_t;

endpackage

/* File: hdl/ceim_event_sel.sv */
`timescale 1ns/1ps
module ceim_event_sel #(
	parameter logic IS_RX = 1'b0
) (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      cfg_we,
	input  wire ceim_pkg::ceim_event_t     cfg_event,
	input  wire ceim_pkg::ceim_client_ev_t ev,
	output logic                           hit
);

	logic                  cfg_q;
	logic                  cfg_d;
	ceim_pkg::ceim_event_t ev_q;
	ceim_pkg::ceim_event_t ev_d;

	// latest legal descriptor wins; an illegal code leaves the old choice alone
	always_comb begin
		cfg_d = cfg_q;
		ev_d  = ev_q;
		if (cfg_we) begin
			unique case (cfg_event)
				ceim_pkg::CEIM_EV_EOF_RX,
				ceim_pkg::CEIM_EV_EOF_TX,
				ceim_pkg::CEIM_EV_SOF,
				ceim_pkg::CEIM_EV_LINE: begin
					cfg_d = 1'b1;
					ev_d  = cfg_event;
				end
				default: begin
					cfg_d = cfg_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg_q <= 1'b0;
			ev_q  <= ceim_pkg::CEIM_EV_EOF_TX;
		end else begin
			cfg_q <= cfg_d;
			ev_q  <= ev_d;
		end
	end

	// unconfigured clients follow end of frame in their data direction
	always_comb begin
		hit = 1'b0;
		if (!cfg_q) begin
			hit = IS_RX ? ev.eof_rx : ev.eof_tx;
		end else begin
			unique case (ev_q)
				ceim_pkg::CEIM_EV_EOF_RX: hit = ev.eof_rx;
				ceim_pkg::CEIM_EV_EOF_TX: hit = ev.eof_tx;
				ceim_pkg::CEIM_EV_SOF:    hit = ev.sof;
				ceim_pkg::CEIM_EV_LINE:   hit = ev.line;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_default_event: assert property (
		!cfg_q |-> (hit == (IS_RX ? ev.eof_rx : ev.eof_tx)))
		else $error("default event does not follow client direction");

	a_config_take: assert property (
		(cfg_we && $onehot(cfg_event)) |=> (cfg_q && ev_q == $past(cfg_event)))
		else $error("descriptor event choice not taken");

endmodule

/* File: hdl/ceim_irq_ctrl.sv */
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Operation
// - A status bit sets when its client hits the event picked by its latest descriptor.
// - Receiving clients default to end of frame received while unconfigured.
// - Sending clients default to end of frame sent while unconfigured.
// - A set status bit stays one until software clears it, whatever further events come.
// - Writing one to a status bit clears it unless its event lands in the same cycle, and only bits written with one clear.
// - The enable word sits at 124h, is 32 bits and resets to zero.
// - An enable bit at one lets the matching status bit drive the second interrupt line.
// - Noise filter clients use bits 17 to 13.
// - Graphics stream clients use bits 12 to 10 and graphics data clients bits 1 and 0.
// - Capture port clients use bits 9 to 2, and bits 29 to 26 for ancillary data, port two first.
module ceim_irq_ctrl (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire ceim_pkg::ceim_bus_req_t bus_req,
	output logic [31:0]                 rdata,
	input  wire ceim_pkg::ceim_desc_t    desc,
	input  wire ceim_pkg::ceim_events_t  events,
	output logic                        second_irq_line
);

	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] enable_q;
	logic [31:0] enable_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        irq_q;
	logic        irq_d;
	logic [31:0] hit;
	logic [31:0] hit_v;
	logic [31:0] clr_v;
	logic        st_wr;
	logic        en_wr;

	// one address compare per register, shared by read and write paths
	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	// per-client event selection; reserved positions never raise an event
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_client
			if (ceim_pkg::IMPL_MASK[gi]) begin : g_impl
				ceim_event_sel #(
					.IS_RX (ceim_pkg::RX_MASK[gi])
				) u_sel (
					.clk       (clk),
					.rstn      (rstn),
					.cfg_we    (desc.valid && desc.client == 5'(gi)),
					.cfg_event (desc.event_sel),
					.ev        ({events.eof_rx[gi], events.eof_tx[gi],
					             events.sof[gi], events.line[gi]}),
					.hit       (hit[gi])
				);
			end else begin : g_rsvd
				assign hit[gi] = 1'b0;
			end
		end
	endgenerate

	// write decode
	assign st_wr = bus_req.wr && addr_is(bus_req.addr, ceim_pkg::STATUS_OFFSET);
	assign en_wr = bus_req.wr && addr_is(bus_req.addr, ceim_pkg::ENABLE_OFFSET);
	assign hit_v = hit & ceim_pkg::IMPL_MASK;
	assign clr_v = st_wr ? (bus_req.wdata & ceim_pkg::IMPL_MASK) : 32'h0000_0000;

	// status: set beats clear so an event landing on a clear write is kept
	always_comb begin
		status_d = ((status_q & ~clr_v) | hit_v) & ceim_pkg::IMPL_MASK;
		enable_d = enable_q;
		if (en_wr) begin
			enable_d = bus_req.wdata & ceim_pkg::IMPL_MASK;
		end
		// computed from next values so the line follows status with no extra lag
		irq_d = |(status_d & enable_d);
	end

	// read data live only in the cycle after the strobe, zero otherwise
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (bus_req.rd) begin
			if (addr_is(bus_req.addr, ceim_pkg::STATUS_OFFSET)) begin
				rdata_d = status_q;
			end else if (addr_is(bus_req.addr, ceim_pkg::ENABLE_OFFSET)) begin
				rdata_d = enable_q;
			end else begin
				rdata_d = 32'h0000_0000; // unmapped reads return zero
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			status_q <= ceim_pkg::STATUS_RESET;
			enable_q <= ceim_pkg::ENABLE_RESET;
			rdata_q  <= 32'h0000_0000;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
			rdata_q  <= rdata_d;
			irq_q    <= irq_d;
		end
	end

	assign rdata           = rdata_q;
	assign second_irq_line = irq_q;

	// helpers read only by the checks below
	logic [31:0] keep_v;
	logic [31:0] drop_v;
	assign keep_v = status_q & ~clr_v;
	assign drop_v = clr_v & ~hit_v;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_clear_write;
		st_wr && (drop_v != 32'h0000_0000);
	endsequence

	sequence s_bits_gone;
		(status_q & $past(drop_v)) == 32'h0000_0000;
	endsequence

	a_set_on_hit: assert property (
		(hit_v != 32'h0000_0000) |=> ((status_q & $past(hit_v)) == $past(hit_v)))
		else $error("client event did not set its status bit");

	a_hold_until_clr: assert property (
		(keep_v != 32'h0000_0000) |=> ((status_q & $past(keep_v)) == $past(keep_v)))
		else $error("status bit dropped without a clear");

	a_clear_w1c: assert property (
		s_clear_write |=> s_bits_gone)
		else $error("written one did not clear status bit");

	a_write_zero: assert property (
		(st_wr && bus_req.wdata == 32'h0000_0000 && hit_v == 32'h0000_0000)
		|=> (status_q == $past(status_q)))
		else $error("zero write changed status");

	a_irq_gating: assert property (
		(status_q & enable_q) == 32'h0000_0000 |-> !second_irq_line)
		else $error("interrupt high with no enabled status");

	a_irq_follows: assert property (
		((status_q & enable_q) != 32'h0000_0000) |-> second_irq_line)
		else $error("interrupt low with an enabled status bit set");

	a_enable_reset: assert property (
		disable iff (1'b0)
		!rstn |=> (enable_q == 32'h0000_0000 && status_q == 32'h0000_0000 && !irq_q))
		else $error("registers not zero after reset");

	a_enable_read: assert property (
		(bus_req.rd && bus_req.addr == ceim_pkg::ENABLE_OFFSET && !$past(en_wr))
		|=> (rdata == $past(enable_q)))
		else $error("enable read back wrong");

	a_reserved_zero: assert property (
		((status_q | enable_q) & ~ceim_pkg::IMPL_MASK) == 32'h0000_0000)
		else $error("reserved bit set");

	a_read_once: assert property (
		!bus_req.rd |=> (rdata == 32'h0000_0000))
		else $error("read data outside its cycle");

endmodule

/* File: dv/ceim_client_model.sv */
`timescale 1ns/1ps
// far-side video clients: event and descriptor pulses, one cycle each, idle low
module ceim_client_model (
	input  wire logic              clk,
	output ceim_pkg::ceim_events_t events,
	output ceim_pkg::ceim_desc_t   desc
);
	// quiet from time zero so the block never sees an unknown pulse
	initial begin
		events = '0;
		desc   = '0;
	end

	// raise a set of client events for exactly one cycle
	task automatic fire(input ceim_pkg::ceim_events_t v);
		@(posedge clk);
		events <= v;
		@(posedge clk);
		events <= '0;
	endtask

	// one control descriptor; it governs events from the following cycle on
	task automatic cfg_send(input logic [4:0] c, input ceim_pkg::ceim_event_t e);
		@(posedge clk);
		desc <= '{valid: 1'b1, client: c, event_sel: e};
		@(posedge clk);
		desc <= '0;
	endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam logic [11:0] STA = ceim_pkg::STATUS_OFFSET;
	localparam logic [11:0] ENA = ceim_pkg::ENABLE_OFFSET;
	logic                    clk;
	logic                    rstn;
	ceim_pkg::ceim_bus_req_t req;
	logic [31:0]             rdata;
	ceim_pkg::ceim_events_t  events;
	ceim_pkg::ceim_desc_t    desc;
	logic                    irq;
	int                      err_total;
	int                      comparisons;

	ceim_irq_ctrl dut (.clk(clk), .rstn(rstn), .bus_req(req), .rdata(rdata),
		.desc(desc), .events(events), .second_irq_line(irq));
	ceim_client_model clients (.clk(clk), .events(events), .desc(desc));

	// 25 MHz
	always #20 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// single-cycle write strobe
	task automatic bwr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic brd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge clk);
		req <= '0;
		#1 chk(rdata, exp);
	endtask

	task automatic t_regs();
		brd(STA, 32'h0000_0000);
		brd(ENA, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		bwr(ENA, 32'hFFFF_FFFF);
		brd(ENA, 32'h3FFB_FFFF);
		brd(12'h128, 32'h0000_0000);
		bwr(ENA, 32'h0000_0000);
	endtask

	// wrong default kind first, then each kind on every low client
	task automatic t_defaults();
		clients.fire('{32'h03D8_FC03, 32'h3C23_03FC, 32'h0, 32'h0});
		brd(STA, 32'h0000_0000);
		clients.fire('{32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0});
		brd(STA, 32'h3C23_03FC);
		clients.fire('{32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0});
		brd(STA, 32'h3FFB_FFFF);
	endtask

	task automatic t_irq();
		#1 chk({31'h0, irq}, 32'h0000_0000);
		bwr(ENA, 32'h0002_0000);
		#1 chk({31'h0, irq}, 32'h0000_0001);
		bwr(STA, 32'h0000_0000);
		brd(STA, 32'h3FFB_FFFF);
		bwr(STA, 32'h0002_0000);
		#1 chk({31'h0, irq}, 32'h0000_0000);
		brd(STA, 32'h3FF9_FFFF);
		bwr(STA, 32'hFFFF_FFFF);
		brd(STA, 32'h0000_0000);
		// clear and event at the same edge: the event must not be lost
		fork
			bwr(STA, 32'h0001_0000);
			clients.fire('{32'h0001_0000, 32'h0, 32'h0, 32'h0});
		join
		brd(STA, 32'h0001_0000);
		// bit 16 is masked, so the line must stay low
		#1 chk({31'h0, irq}, 32'h0000_0000);
		bwr(STA, 32'h0001_0000);
	endtask

	// every selectable event on client 0; only the chosen kind may set it
	task automatic t_desc();
		logic [127:0] all;
		logic [127:0] hit;
		all = {32'h1, 32'h1, 32'h1, 32'h1};
		for (int k = 0; k < 4; k++) begin
			hit = 128'h1 << (96 - 32 * k);
			clients.cfg_send(5'd0, ceim_pkg::ceim_event_t'(4'h1 << k));
			clients.fire(ceim_pkg::ceim_events_t'(all ^ hit));
			brd(STA, 32'h0000_0000);
			clients.fire(ceim_pkg::ceim_events_t'(hit));
			brd(STA, 32'h0000_0001);
			bwr(STA, 32'h0000_0001);
		end
	endtask

	// reset in mid-run must drop enables, status and descriptor choices
	task automatic t_reset();
		clients.cfg_send(5'd0, ceim_pkg::CEIM_EV_SOF);
		bwr(ENA, 32'h0000_0001);
		clients.fire('{32'h0, 32'h0, 32'h0000_0001, 32'h0});
		#1 chk({31'h0, irq}, 32'h0000_0001);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1 chk({31'h0, irq}, 32'h0000_0000);
		brd(ENA, 32'h0000_0000);
		brd(STA, 32'h0000_0000);
		clients.fire('{32'h0, 32'h0000_0001, 32'h0, 32'h0});
		brd(STA, 32'h0000_0001);
		bwr(STA, 32'h0000_0001);
	endtask

	task automatic final_report();
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		clk         = 1'b0;
		rstn        = 1'b0;
		req         = '0;
		err_total   = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_defaults();
		t_irq();
		t_desc();
		t_reset();
		final_report();
	end

	// the sequence needs about 120 cycles; this leaves a wide margin
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		final_report();
	end
endmodule
